// ===== include/i2sf_pkg.sv
// Constants, register map and helpers of the I2C status-flag block.
// Assumes a 50 MHz module clock and a sampled I2C line.
// Notes on behaviour
// - START sets the bus occupied flag.
// - STOP or reset clears bus occupied.
// - New byte while data unread sets overrun.
// - Shift keeps running; copy after CPU read.
// - CPU data read clears overrun; debug doesn't.
// - Empty shifter, no new data: flag low.
// - No transfer until written; old byte resent.
// - Data write or reset sets shift-nonempty flag.
// - Own or general-call address sets addressed.
// - Free format: first byte sets addressed.
// - 7-bit: NACK, STOP, restart clear addressed.
// - 10-bit: NACK, STOP, foreign address clear.
// - All-zeros write address sets general-call flag, except in free format.
// - START or STOP clears general-call flag.
// - Status bits 7 and 6 read zero.
package i2sf_pkg;
  // ****************************************
  // Register map (word indices)
  // ****************************************
  localparam int          AW          = 4;      // Address width
  localparam int          DW          = 16;     // Data width
  localparam logic [3:0]  REG_STATUS  = 4'h0;   // bus_status_flags
  localparam logic [3:0]  REG_CTRL    = 4'h1;   // Own address, modes
  localparam logic [3:0]  REG_RXDATA  = 4'h2;   // receive_data_register
  localparam logic [3:0]  REG_TXDATA  = 4'h3;   // transmit_data_register
  localparam logic [3:0]  REG_EVENT   = 4'h4;   // Sticky events, W1C
  localparam logic [3:0]  REG_MASK    = 4'h5;   // Event mask
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          ST_BB       = 12;     // bus_occupied_flag
  localparam int          ST_OVR      = 11;     // receive_overrun_flag
  localparam int          ST_TRANSMIT_SHIFT_NONEMPTY_FLAG     = 10;     // transmit_shift_nonempty_flag
  localparam int          ST_AAS      = 9;      // addressed_as_target_flag
  localparam int          ST_GC       = 8;      // general_call_flag
  localparam int          ST_RRDY     = 3;      // Receive data waiting
  localparam int          CT_TEN      = 10;     // Ten-bit addressing
  localparam int          CT_FREE     = 11;     // free_format_select
  localparam int          EV_W        = 6;      // Event bits
  localparam int          EV_START    = 0;
  localparam int          EV_STOP     = 1;
  localparam int          EV_RXBYTE   = 2;
  localparam int          EV_OVR      = 3;
  localparam int          EV_UNDER    = 4;
  localparam int          EV_ADDR     = 5;
  localparam logic [9:0]  OWN_RST     = 10'h000;
  localparam logic        TRANSMIT_SHIFT_NONEMPTY_FLAG_RST    = 1'b1;
  localparam logic        LINE_IDLE   = 1'b1;   // Released line level
  localparam logic [4:0]  TEN_TAG     = 5'h1E;  // Ten-bit header marker
  localparam logic [3:0]  ACK_SLOT    = 4'h8;   // Bit index of ack slot
  localparam logic [3:0]  LAST_BIT    = 4'h7;

  // All-zeros address with write direction
  function automatic logic is_gc(input logic [7:0] b);
    return (b[7:1] == 7'h00) && !b[0];
  endfunction : is_gc
endpackage : i2sf_pkg

// ===== include/i2sf_line_if.sv
// Signals shared by the line monitor, the shifter and the flag core.
// Assumes all signals live on the module clock.
`timescale 1ns/1ps
interface i2sf_line_if;
  logic       scl_rise;   // Sampled SCL rising edge, pulse
  logic       scl_fall;   // Sampled SCL falling edge, pulse
  logic       start_det;  // START or repeated START, pulse
  logic       stop_det;   // STOP, pulse
  logic       sda;        // Synchronised SDA level
  logic [7:0] rsr;        // receive_shift_register
  logic       byte_done;  // Eight bits assembled, pulse
  logic       ack_done;   // Ack slot sampled, pulse
  logic       ack_bit;    // Ack slot level, 1 = NACK
  logic       sda_oe;     // Pull SDA low
  logic       tx_mode;    // Drive data bits
  logic       ack_en;     // Drive ack in next slot
  logic       xsr_load;   // Load transmit_shift_register
  logic [7:0] xsr_data;   // Byte to load

  modport mon (output scl_rise, scl_fall, start_det, stop_det, sda);
  modport shf (input scl_rise, scl_fall, start_det, stop_det, sda,
               tx_mode, ack_en, xsr_load, xsr_data,
               output rsr, byte_done, ack_done, ack_bit, sda_oe);
endinterface : i2sf_line_if

// ===== rtl/i2sf_line_mon.sv
// Line monitor: synchronises SCL and SDA and finds edges, START, STOP.
// Assumes SCL is slow against the clock (several clocks per level).
`timescale 1ns/1ps
module i2sf_line_mon
  import i2sf_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  i2sf_line_if.mon  mon
);
  // ****************************************
  // Synchronisers and history
  // ****************************************
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;  // SCL stages
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;  // SDA stages

  // Two stages per pin plus a history stage; stage two and the history stage feed logic
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_s1_ff <= LINE_IDLE;
      scl_s2_ff <= LINE_IDLE;
      scl_d_ff  <= LINE_IDLE;
      sda_s1_ff <= LINE_IDLE;
      sda_s2_ff <= LINE_IDLE;
      sda_d_ff  <= LINE_IDLE;
    end else begin
      scl_s1_ff <= scl_pin;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff  <= scl_s2_ff;
      sda_s1_ff <= sda_pin;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff  <= sda_s2_ff;
    end
  end

  // ****************************************
  // Edge and condition decode
  // ****************************************
  wire logic scl_hi = scl_s2_ff && scl_d_ff;  // SCL high both samples
  assign mon.scl_rise  = scl_s2_ff && !scl_d_ff;
  assign mon.scl_fall  = !scl_s2_ff && scl_d_ff;
  assign mon.start_det = scl_hi && sda_d_ff && !sda_s2_ff;  // SDA falls
  assign mon.stop_det  = scl_hi && !sda_d_ff && sda_s2_ff;  // SDA rises
  assign mon.sda       = sda_s2_ff;
endmodule : i2sf_line_mon

// ===== rtl/i2sf_shifter.sv
// Bit shifter: counts bits, assembles received bytes, drives SDA.
// Assumes the core sets tx_mode and ack_en well before the SCL fall.
`timescale 1ns/1ps
module i2sf_shifter
  import i2sf_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  i2sf_line_if.shf  shf
);
  // ****************************************
  // State
  // ****************************************
  logic [3:0] cnt_ff;        // Bit index, 8 = ack slot
  logic [7:0] rsr_ff;        // Received bits
  logic [7:0] xsr_ff;        // Byte being sent
  logic       oe_ff;         // SDA pull-down
  logic       byte_done_ff;  // Byte assembled
  logic       ack_done_ff;   // Ack slot sampled
  logic       ack_bit_ff;    // Sampled ack level

  wire logic in_ack = (cnt_ff == ACK_SLOT);
  // Bit is not shifted out: a missed reload resends it whole
  wire logic tx_bit = xsr_ff[3'd7 - cnt_ff[2:0]];

  // Counting and sampling on SCL rise
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_ff       <= 4'h0;
      rsr_ff       <= 8'h00;
      byte_done_ff <= 1'b0;
      ack_done_ff  <= 1'b0;
      ack_bit_ff   <= 1'b0;
    end else begin
      byte_done_ff <= shf.scl_rise && (cnt_ff == LAST_BIT);
      ack_done_ff  <= shf.scl_rise && in_ack;
      if (shf.start_det || shf.stop_det) begin
        cnt_ff <= 4'h0;  // Frame boundary
      end else if (shf.scl_rise) begin
        cnt_ff <= in_ack ? 4'h0 : cnt_ff + 4'h1;
      end
      // Shifts on every data-bit SCL rise, even while the old byte is unread
      if (shf.scl_rise && !in_ack) begin
        rsr_ff <= {rsr_ff[6:0], shf.sda};
      end
      if (shf.scl_rise && in_ack) begin
        ack_bit_ff <= shf.sda;
      end
    end
  end

  // Transmit byte loaded on xsr_load; SDA drive changed on SCL fall or frame edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      xsr_ff <= 8'h00;
      oe_ff  <= 1'b0;
    end else begin
      if (shf.xsr_load) begin
        xsr_ff <= shf.xsr_data;
      end
      if (shf.start_det || shf.stop_det) begin
        oe_ff <= 1'b0;  // Release at frame edge
      end else if (shf.scl_fall) begin
        oe_ff <= in_ack ? shf.ack_en : (shf.tx_mode && !tx_bit);
      end
    end
  end

  assign shf.rsr       = rsr_ff;
  assign shf.byte_done = byte_done_ff;
  assign shf.ack_done  = ack_done_ff;
  assign shf.ack_bit   = ack_bit_ff;
  assign shf.sda_oe    = oe_ff;
endmodule : i2sf_shifter

// ===== rtl/i2sf_top.sv
// Status-flag core of an I2C target: flags, data registers, events.
// Assumes a register port on the module clock and an open-drain SDA
// resolved outside; SCL is only observed, never stretched.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module i2sf_top
  import i2sf_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  input  wire logic          read_by_cpu,
  output logic      [DW-1:0] reg_rdata,
  input  wire logic          scl_pin,
  input  wire logic          sda_pin,
  output logic               sda_out,
  output logic               sda_oe,
  output logic               irq
);
  // ****************************************
  // Sub-blocks
  // ****************************************
  i2sf_line_if lnk ();  // Shared line signals

  i2sf_line_mon u_mon (
    .clock   (clock),
    .reset   (reset),
    .scl_pin (scl_pin),
    .sda_pin (sda_pin),
    .mon     (lnk.mon)
  );

  i2sf_shifter u_shf (
    .clock (clock),
    .reset (reset),
    .shf   (lnk.shf)
  );

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    PH_IDLE,   // No frame
    PH_ADDR,   // First byte after START
    PH_ADDR2,  // Low byte of ten-bit address
    PH_RX,     // Receiving data
    PH_TX,     // Sending data
    PH_SKIP    // Not for us
  } i2sf_phase_t;

  i2sf_phase_t       phase_ff;    // Frame phase
  i2sf_phase_t       nxt_phase;
  logic [9:0]        own_ff;      // Own target address
  logic              ten_ff;      // Ten-bit addressing
  logic              free_ff;     // free_format_select
  logic              bb_ff;       // bus_occupied_flag
  logic              ovr_ff;      // receive_overrun_flag
  logic              transmit_shift_nonempty_flag_ff;     // transmit_shift_nonempty_flag
  logic              aas_ff;      // addressed_as_target_flag
  logic              gc_ff;       // general_call_flag
  logic              rrdy_ff;     // Receive data waiting
  logic              pend_ff;     // Shifted byte held back
  logic [7:0]        drr_ff;      // receive_data_register
  logic [7:0]        dxr_ff;      // transmit_data_register
  logic              dxr_new_ff;  // Written since last transfer
  logic              ack_en_ff;   // Ack the next slot
  logic [EV_W-1:0]   evt_ff;      // Sticky events
  logic [EV_W-1:0]   mask_ff;     // Event mask
  logic [DW-1:0]     rdata_ff;    // Read data, one cycle late

  // ****************************************
  // Register decode
  // ****************************************
  wire logic wr_ctrl = reg_write && (reg_addr == REG_CTRL);
  wire logic wr_tx   = reg_write && (reg_addr == REG_TXDATA);
  wire logic wr_evt  = reg_write && (reg_addr == REG_EVENT);
  wire logic wr_mask = reg_write && (reg_addr == REG_MASK);
  // Debug reads of the data register leave every flag alone
  wire logic rd_side = reg_read && read_by_cpu
                       && (reg_addr == REG_RXDATA);

  // ****************************************
  // Address decode
  // ****************************************
  wire logic [7:0] rx_byte = lnk.rsr;
  wire logic       rw      = rx_byte[0];
  wire logic       gc_hit  = is_gc(rx_byte);
  wire logic       own7    = rx_byte[7:1] == own_ff[6:0];
  wire logic       hdr10   = (rx_byte[7:3] == TEN_TAG)
                             && (rx_byte[2:1] == own_ff[9:8]);
  wire logic       low10   = rx_byte == own_ff[7:0];
  wire logic       in_addr  = lnk.byte_done && (phase_ff == PH_ADDR);
  wire logic       in_addr2 = lnk.byte_done && (phase_ff == PH_ADDR2);
  wire logic       addr_ok  = free_ff || gc_hit
                              || (!ten_ff && own7)
                              || (ten_ff && hdr10 && rw && aas_ff);
  // Master NACK ends our transmission
  wire logic       nack    = lnk.ack_done && (phase_ff == PH_TX)
                             && lnk.ack_bit;
  // Header of a foreign ten-bit address, or a foreign low byte
  wire logic       foreign10 = ten_ff && !free_ff
                               && ((in_addr && !gc_hit && !hdr10)
                                   || (in_addr2 && !low10));

  // ****************************************
  // Phase machine
  // ****************************************
  // Next phase; START and STOP override the byte flow
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_ADDR: begin
        if (lnk.byte_done) begin
          if (free_ff) begin
            nxt_phase = PH_RX;  // First byte is data
          end else if (ten_ff && hdr10) begin
            nxt_phase = rw ? (aas_ff ? PH_TX : PH_SKIP) : PH_ADDR2;
          end else if (gc_hit) begin
            nxt_phase = PH_RX;
          end else if (!ten_ff && own7) begin
            nxt_phase = rw ? PH_TX : PH_RX;
          end else begin
            nxt_phase = PH_SKIP;
          end
        end
      end
      PH_ADDR2: begin
        if (lnk.byte_done) begin
          nxt_phase = low10 ? PH_RX : PH_SKIP;
        end
      end
      PH_TX: begin
        if (nack) begin
          nxt_phase = PH_SKIP;
        end
      end
      PH_IDLE, PH_RX, PH_SKIP: begin
        nxt_phase = phase_ff;  // Wait for a frame edge
      end
    endcase
    if (lnk.start_det) begin
      nxt_phase = PH_ADDR;
    end else if (lnk.stop_det) begin
      nxt_phase = PH_IDLE;
    end
  end

  // Ack address bytes we own and every received data byte
  wire logic nxt_ack_en = lnk.byte_done
                          && ((nxt_phase == PH_RX)
                              || (nxt_phase == PH_ADDR2)
                              || (in_addr && nxt_phase == PH_TX));

  // ****************************************
  // Bus occupied and general call
  // ****************************************
  wire logic nxt_bb = lnk.start_det
                      || (bb_ff && !lnk.stop_det);
  wire logic gc_set = in_addr && !free_ff && gc_hit;
  wire logic nxt_gc = gc_set
                      || (gc_ff && !lnk.start_det && !lnk.stop_det);

  // ****************************************
  // Addressed as target
  // ****************************************
  wire logic aas_set = (in_addr && addr_ok)
                       || (in_addr2 && low10);
  wire logic aas_clr = lnk.stop_det || nack
                       || (lnk.start_det && !ten_ff)
                       || foreign10;
  // Set wins over a clear in the same cycle
  wire logic nxt_aas = aas_set || (aas_ff && !aas_clr);

  // ****************************************
  // Receive path and overrun
  // ****************************************
  wire logic rx_evt  = lnk.byte_done
                       && ((phase_ff == PH_RX) || (in_addr && free_ff));
  // Byte moves up only when the data register is free or being read
  wire logic rx_take = rx_evt && (!rrdy_ff || rd_side);
  wire logic ovr_set = rx_evt && !rx_take;
  // Held byte comes from the live shifter, which may hold new bits
  wire logic drr_load = rx_take || (rd_side && pend_ff);
  wire logic nxt_ovr  = ovr_set || (ovr_ff && !rd_side);
  wire logic nxt_pend = rx_evt ? ovr_set : (pend_ff && !rd_side);
  wire logic nxt_rrdy = rx_take || (rd_side ? pend_ff : rrdy_ff);

  // ****************************************
  // Transmit path and underflow
  // ****************************************
  wire logic tx_need  = lnk.ack_done && (phase_ff == PH_TX)
                        && !lnk.ack_bit;
  wire logic tx_fresh = dxr_new_ff || wr_tx;  // Write in same cycle counts
  wire logic under    = tx_need && !tx_fresh;
  assign lnk.xsr_load = tx_need && tx_fresh;
  assign lnk.xsr_data = wr_tx ? reg_wdata[7:0] : dxr_ff;
  assign lnk.tx_mode  = (phase_ff == PH_TX);
  assign lnk.ack_en   = ack_en_ff;
  // CPU write sets, underflow clears; the write wins
  wire logic nxt_transmit_shift_nonempty_flag = wr_tx || (transmit_shift_nonempty_flag_ff && !under);
  wire logic nxt_dxr_new = wr_tx ? !tx_need : (dxr_new_ff && !tx_need);

  // ****************************************
  // Events and interrupt
  // ****************************************
  wire logic [EV_W-1:0] ev_set = {aas_set && !aas_ff, under, ovr_set,
                                  rx_take, lnk.stop_det, lnk.start_det};
  wire logic [EV_W-1:0] ev_clr = wr_evt ? reg_wdata[EV_W-1:0] : '0;
  wire logic [EV_W-1:0] nxt_evt = (evt_ff & ~ev_clr) | ev_set;

  // ****************************************
  // Read side
  // ****************************************
  logic [DW-1:0] status_word;  // Bits 7 and 6 stay zero

  // Status image assembled bit by bit
  always_comb begin
    status_word          = '0;
    status_word[ST_BB]   = bb_ff;
    status_word[ST_OVR]  = ovr_ff;
    status_word[ST_TRANSMIT_SHIFT_NONEMPTY_FLAG] = transmit_shift_nonempty_flag_ff;
    status_word[ST_AAS]  = aas_ff;
    status_word[ST_GC]   = gc_ff;
    status_word[ST_RRDY] = rrdy_ff;
  end

  wire logic [DW-1:0] ctrl_word = {4'h0, free_ff, ten_ff, own_ff};
  wire logic [DW-1:0] rd_mux =
    (reg_addr == REG_STATUS) ? status_word :
    (reg_addr == REG_CTRL)   ? ctrl_word :
    (reg_addr == REG_RXDATA) ? {8'h00, drr_ff} :
    (reg_addr == REG_TXDATA) ? {8'h00, dxr_ff} :
    (reg_addr == REG_EVENT)  ? {10'h000, evt_ff} :
    (reg_addr == REG_MASK)   ? {10'h000, mask_ff} : '0;

  // ****************************************
  // Flag registers
  // ****************************************
  // Status flags and phase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_ff  <= PH_IDLE;
      bb_ff     <= 1'b0;
      ovr_ff    <= 1'b0;
      transmit_shift_nonempty_flag_ff   <= TRANSMIT_SHIFT_NONEMPTY_FLAG_RST;
      aas_ff    <= 1'b0;
      gc_ff     <= 1'b0;
      rrdy_ff   <= 1'b0;
      pend_ff   <= 1'b0;
      ack_en_ff <= 1'b0;
    end else begin
      phase_ff  <= nxt_phase;
      bb_ff     <= nxt_bb;
      ovr_ff    <= nxt_ovr;
      transmit_shift_nonempty_flag_ff   <= nxt_transmit_shift_nonempty_flag;
      aas_ff    <= nxt_aas;
      gc_ff     <= nxt_gc;
      rrdy_ff   <= nxt_rrdy;
      pend_ff   <= nxt_pend;
      ack_en_ff <= nxt_ack_en || (ack_en_ff && !lnk.ack_done
                   && !lnk.start_det && !lnk.stop_det);
    end
  end

  // Data, control and event registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      own_ff     <= OWN_RST;
      ten_ff     <= 1'b0;
      free_ff    <= 1'b0;
      drr_ff     <= 8'h00;
      dxr_ff     <= 8'h00;
      dxr_new_ff <= 1'b0;
      evt_ff     <= '0;
      mask_ff    <= '0;
      rdata_ff   <= '0;
    end else begin
      if (wr_ctrl) begin
        own_ff  <= reg_wdata[9:0];
        ten_ff  <= reg_wdata[CT_TEN];
        free_ff <= reg_wdata[CT_FREE];
      end
      if (drr_load) begin
        drr_ff <= rx_byte;
      end
      if (wr_tx) begin
        dxr_ff <= reg_wdata[7:0];
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata[EV_W-1:0];
      end
      dxr_new_ff <= nxt_dxr_new;
      evt_ff     <= nxt_evt;
      // Data stand only in the cycle after the read
      rdata_ff   <= reg_read ? rd_mux : '0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_ff;
  assign sda_out   = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe    = lnk.sda_oe;
  assign irq       = |(evt_ff & mask_ff);
endmodule : i2sf_top

// ===== sim/i2sf_top_properties.sv
// Checker of the status-flag core, on its register and pin ports.
// Assumes binding to i2sf_top; one clock domain, async reset.
`timescale 1ns/1ps
module i2sf_top_checker
  import i2sf_pkg::*;
(
  input wire logic          clock,
  input wire logic          reset,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic          reg_write,
  input wire logic          reg_read,
  input wire logic          read_by_cpu,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic          scl_pin,
  input wire logic          sda_pin,
  input wire logic          sda_out,
  input wire logic          sda_oe,
  input wire logic          irq
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Read data only in the slot after a read
  property p_rd_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_resv; $past(reg_read) && $past(reg_addr) == REG_STATUS |-> reg_rdata[7:6] == 2'b00; endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_st_hi; $past(reg_read) && $past(reg_addr) == REG_STATUS |-> reg_rdata[15:13] == 3'h0; endproperty
  a_st_hi: assert property (p_st_hi) else $error("unused status bits set");
  // Data register is a byte wide
  property p_rx_hi; $past(reg_read) && $past(reg_addr) == REG_RXDATA |-> reg_rdata[15:8] == 8'h00; endproperty
  a_rx_hi: assert property (p_rx_hi) else $error("receive data upper byte set");
  property p_unmap; $past(reg_read) && $past(reg_addr) > REG_MASK |-> reg_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Open drain: only the enable ever moves
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_irq_off; reg_write && reg_addr == REG_MASK && reg_wdata[5:0] == 6'h00 |=> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all masked");
  property p_transmit_shift_nonempty_flag; reg_write && reg_addr == REG_TXDATA ##2 reg_read && reg_addr == REG_STATUS |=> reg_rdata[ST_TRANSMIT_SHIFT_NONEMPTY_FLAG]; endproperty
  a_transmit_shift_nonempty_flag: assert property (p_transmit_shift_nonempty_flag) else $error("shift flag low after write");
endmodule : i2sf_top_checker

bind i2sf_top i2sf_top_checker u_i2sf_top_checker (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .read_by_cpu, .reg_rdata, .scl_pin, .sda_pin, .sda_out, .sda_oe, .irq);

// ===== sim/i2sf_ctl_model.sv
// Behavioural bus controller driving the target's serial pins.
// Assumes an open-drain data line with pull-up resolved outside.
`timescale 1ns/1ps
module i2sf_ctl_model (
  output logic      scl,      // Serial clock, still high when idle
  output logic      sda_drv,  // 0 pulls data low, 1 releases
  input  wire logic sda_line  // Resolved data level
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // ****************
  // Bus cycles, 160 ns per bit
  // ****************
  // START or repeated START; offset keeps pin edges off clock edges
  task start();
    #5 sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #80 scl = 1'b0;
  endtask : start
  // One bit: drive, raise clock, sample mid-high, lower
  task clk_bit(input logic v, output logic s);
    #40 sda_drv = v;
    #40 scl = 1'b1;
    #40 s = sda_line;
    #40 scl = 1'b0;
  endtask : clk_bit
  task wr_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, nack);
  endtask : wr_byte
  task rd_byte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(nack, s);
  endtask : rd_byte
  task stop();
    #40 sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask : stop
endmodule : i2sf_ctl_model

// ===== sim/i2sf_top_tb.sv
// Self-checking bench of the status-flag core with a controller model.
// Assumes the checker binds itself; pull-up resolves the data line.
`timescale 1ns/1ps
module i2sf_top_tb;
  import i2sf_pkg::*;
  logic          clock       = 1'b0;
  logic          reset       = 1'b1;
  logic [AW-1:0] reg_addr    = 4'h0;
  logic [DW-1:0] reg_wdata   = 16'h0000;
  logic          reg_write   = 1'b0;
  logic          reg_read    = 1'b0;
  logic          read_by_cpu = 1'b0;
  logic [DW-1:0] reg_rdata, d;
  logic          scl, sda_drv, sda_out, sda_oe, irq, a;
  logic [7:0]    b;
  int            err_count = 0, n_compared = 0, cyc = 0;
  wire           sda_line = sda_drv & ~sda_oe;  // Pull-up wins when released
  i2sf_ctl_model ctl (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  i2sf_top u_i2sf_top (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .read_by_cpu,
    .reg_rdata, .scl_pin(scl), .sda_pin(sda_line), .sda_out, .sda_oe, .irq);
  always #10 clock = ~clock;
  // ****************
  // Access tasks
  // ****************
  task wr(input logic [AW-1:0] ad, input logic [DW-1:0] v);
    @(posedge clock);
    reg_addr  <= ad;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [AW-1:0] ad, input logic c, output logic [DW-1:0] v);
    @(posedge clock);
    reg_addr    <= ad;
    read_by_cpu <= c;
    reg_read    <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : chk
  // Status after the line settles through the synchronisers
  task st(input logic [15:0] exp);
    repeat (4) @(posedge clock);
    rd(REG_STATUS, 1'b1, d);
    chk(d, exp, "status");
  endtask : st
  task final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Hang guard, far above the roughly one thousand cycles needed
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    st(16'h0400);
    wr(REG_STATUS, 16'hFFFF);
    st(16'h0400);
    rd(4'hF, 1'b1, d);
    chk(d, 16'h0000, "unmapped");
    $display("test reset done");
    wr(REG_CTRL, 16'h002A);
    wr(REG_MASK, 16'h0001);
    ctl.start();
    st(16'h1400);
    ctl.wr_byte(8'h54, a);
    chk({15'h0, a}, 16'h0000, "ack");
    st(16'h1600);
    chk({15'h0, irq}, 16'h0001, "irq");
    wr(REG_EVENT, 16'h003F);
    #1 chk({15'h0, irq}, 16'h0000, "irq");
    ctl.wr_byte(8'h11, a);
    ctl.wr_byte(8'h22, a);
    st(16'h1E08);
    rd(REG_RXDATA, 1'b0, d);
    chk(d, 16'h0011, "rx debug");
    st(16'h1E08);
    rd(REG_RXDATA, 1'b1, d);
    chk(d, 16'h0011, "rx first");
    st(16'h1608);
    rd(REG_RXDATA, 1'b1, d);
    chk(d, 16'h0022, "rx second");
    ctl.stop();
    st(16'h0400);
    $display("test overrun done");
    ctl.start();
    ctl.wr_byte(8'h00, a);
    st(16'h1700);
    ctl.start();
    st(16'h1400);
    ctl.stop();
    $display("test general call done");
    wr(REG_TXDATA, 16'h00A5);
    rd(REG_STATUS, 1'b1, d);
    chk(d, 16'h0400, "status");
    ctl.start();
    ctl.wr_byte(8'h55, a);
    ctl.rd_byte(b, 1'b0);
    chk({8'h00, b}, 16'h00A5, "tx byte");
    ctl.rd_byte(b, 1'b1);
    chk({8'h00, b}, 16'h00A5, "resent");
    st(16'h1000);
    wr(REG_TXDATA, 16'h005A);
    st(16'h1400);
    ctl.stop();
    $display("test underflow done");
    wr(REG_CTRL, 16'h042A);
    ctl.start();
    ctl.wr_byte(8'hF0, a);
    ctl.wr_byte(8'h2A, a);
    st(16'h1600);
    ctl.start();
    ctl.wr_byte(8'hF2, a);
    st(16'h1400);
    ctl.stop();
    $display("test ten bit done");
    wr(REG_CTRL, 16'h0800);
    ctl.start();
    ctl.wr_byte(8'h77, a);
    rd(REG_STATUS, 1'b1, d);
    chk(d & 16'h0200, 16'h0200, "free");
    ctl.stop();
    wr(REG_MASK, 16'h0000);
    $display("test free format done");
    final_report();
  end
endmodule : i2sf_top_tb
